// ---- hdl/imss_flag_if.sv ----
`timescale 1ns/1ns
interface imss_flag_if;
    logic accel_evt;
    logic gyro_evt;
    logic mag_evt;
    logic orient_evt;
    logic mag_en;
    logic rd_clear;
    logic [7:0] data_status;
    logic ovrn_evt;
    modport core (output accel_evt, gyro_evt, mag_evt, orient_evt, mag_en, rd_clear,
                  input data_status, ovrn_evt);
    modport flags (input accel_evt, gyro_evt, mag_evt, orient_evt, mag_en, rd_clear,
                   output data_status, ovrn_evt);
endinterface

// ---- hdl/imss_pkg.sv ----
package imss_pkg;
    // Printed offsets are word indices; byte address is four times the index
    localparam logic [7:0] IMSS_IDX_DATA_STATUS = 8'h16;
    localparam logic [7:0] IMSS_IDX_MISC = 8'h17;
    localparam logic [7:0] IMSS_IDX_TSTAMP = 8'h18;
    localparam logic [7:0] IMSS_IDX_CTRL = 8'h20;
    localparam logic [7:0] IMSS_IDX_IRQ_STAT = 8'h21;
    localparam logic [7:0] IMSS_IDX_IRQ_MASK = 8'h22;
    localparam logic [7:0] IMSS_IDX_SNAPSHOT = 8'h23;

    // output_data_status fields
    localparam int IMSS_ST0_ORIENT_OVRN = 7;
    localparam int IMSS_ST0_MAG_OVRN = 6;
    localparam int IMSS_ST0_GYRO_OVRN = 5;
    localparam int IMSS_ST0_ACCEL_OVRN = 4;
    localparam int IMSS_ST0_ORIENT_NEW = 3;
    localparam int IMSS_ST0_MAG_VALID = 2;
    localparam int IMSS_ST0_GYRO_NEW = 1;
    localparam int IMSS_ST0_ACCEL_NEW = 0;

    // misc_status fields
    localparam int IMSS_MISC_WAKEUP = 2;
    localparam int IMSS_MISC_FIFO_READY = 1;
    localparam int IMSS_MISC_CMD_DONE = 0;

    // control fields
    localparam int IMSS_CTRL_ACCEL_EN = 0;
    localparam int IMSS_CTRL_GYRO_EN = 1;
    localparam int IMSS_CTRL_MAG_EN = 2;
    localparam int IMSS_CTRL_ORIENT_EN = 3;
    localparam int IMSS_CTRL_LEVEL_SEL = 7;

    // interrupt status fields
    localparam int IMSS_IRQ_DATA = 0;
    localparam int IMSS_IRQ_OVRN = 1;
    localparam int IMSS_IRQ_WAKEUP = 2;
    localparam int IMSS_IRQ_CMD = 3;

    localparam logic [7:0] IMSS_RST_BYTE = 8'h00;
    localparam logic [3:0] IMSS_RST_IRQ = 4'h0;
    localparam logic [31:0] IMSS_RST_WORD = 32'h0000_0000;
    localparam logic [2:0] IMSS_HSIZE_WORD = 3'h2;

    typedef enum logic [0:0] {
        IMSS_RD_LIVE = 1'b0,
        IMSS_RD_FROZEN = 1'b1
    } imss_rd_state_t;
endpackage

// ---- hdl/imss_sample_flags.sv ----
`timescale 1ns/1ns
module imss_sample_flags
    import imss_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    imss_flag_if.flags fl
);
    logic [3:0] new_ff;
    logic [3:0] ovrn_ff;
    logic mag_valid_ff;
    // Index order: accel, gyro, mag, orientation
    wire [3:0] evt = {fl.orient_evt, fl.mag_evt, fl.gyro_evt, fl.accel_evt};
    // A sample lost only if its predecessor is unread and not being read now
    wire [3:0] ovrn_set = evt & new_ff & {4{~fl.rd_clear}};
    wire [3:0] clr = {4{fl.rd_clear}};
    wire [3:0] nxt_new = (new_ff & ~clr) | evt;
    wire [3:0] nxt_ovrn = (ovrn_ff & ~clr) | ovrn_set;
    // Held valid while enabled; the held result is repeated between updates
    wire nxt_mag_valid = fl.mag_en & (mag_valid_ff | fl.mag_evt);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            new_ff <= IMSS_RST_IRQ;
            ovrn_ff <= IMSS_RST_IRQ;
            mag_valid_ff <= 1'b0;
        end else begin
            new_ff <= nxt_new; // R04 R05 R06 R16
            ovrn_ff <= nxt_ovrn; // R01 R02 R16
            mag_valid_ff <= nxt_mag_valid; // R07
        end
    end

    assign fl.ovrn_evt = |ovrn_set;
    always_comb begin
        fl.data_status = IMSS_RST_BYTE;
        fl.data_status[IMSS_ST0_ORIENT_OVRN] = ovrn_ff[3]; // R01
        fl.data_status[IMSS_ST0_MAG_OVRN] = ovrn_ff[2]; // R01 R03
        fl.data_status[IMSS_ST0_GYRO_OVRN] = ovrn_ff[1]; // R02
        fl.data_status[IMSS_ST0_ACCEL_OVRN] = ovrn_ff[0]; // R02
        fl.data_status[IMSS_ST0_ORIENT_NEW] = new_ff[3]; // R04
        fl.data_status[IMSS_ST0_MAG_VALID] = mag_valid_ff; // R07
        fl.data_status[IMSS_ST0_GYRO_NEW] = new_ff[1]; // R05
        fl.data_status[IMSS_ST0_ACCEL_NEW] = new_ff[0]; // R06
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_gyro_unread_hit;
        new_ff[1] && !fl.rd_clear ##0 fl.gyro_evt;
    endsequence
    sequence s_orient_unread_hit;
        new_ff[3] && !fl.rd_clear ##0 fl.orient_evt;
    endsequence

    chk_accel_new_set: assert property (fl.accel_evt |=> fl.data_status[0]) // R06
        else $error("accel new flag not set");
    chk_gyro_new_set: assert property (fl.gyro_evt |=> fl.data_status[1]) // R05
        else $error("gyro new flag not set");
    chk_orient_new_set: assert property (fl.orient_evt |=> fl.data_status[3]) // R04
        else $error("orientation new flag not set");
    chk_gyro_ovrn_set: assert property (s_gyro_unread_hit |=> fl.data_status[5]) // R02
        else $error("gyro overrun missed");
    chk_orient_ovrn_set: assert property (s_orient_unread_hit |=> fl.data_status[7]) // R01
        else $error("orientation overrun missed");
    chk_mag_ovrn_bit: assert property (
        (new_ff[2] && !fl.rd_clear && fl.mag_evt) |=> fl.data_status[6] ##1 // R03
        (fl.data_status[6] || $past(fl.rd_clear)))
        else $error("mag overrun not held until read");
    chk_read_clears: assert property (
        (fl.rd_clear && evt == 4'h0) |=> (fl.data_status & 8'hfb) == 8'h00) // R16
        else $error("read did not clear flags");
    chk_mag_valid_off: assert property (!fl.mag_en |=> !fl.data_status[2]) // R07
        else $error("mag valid while disabled");
endmodule

// ---- hdl/imss_status_top.sv ----
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
// Functional notes
// R01: Orientation and magnetometer overrun bits 7/6 set when unread result replaced.
// R02: Gyro and accel overrun bits 5/4 set when unread samples overwritten.
// R03: Magnetometer overrun shown in bit 6; zero means nothing lost.
// R04: Orientation new-result bit 3 set on update, zero if unchanged since read.
// R05: Gyro new-sample bit 1 set on fresh samples, zero since last read.
// R06: Accel new-sample bit 0 set on fresh samples, zero since last read.
// R07: Bit 2 reports magnetometer result valid at every output tick.
// R08: Slower magnetometer result repeats at each fast tick until a new one.
// R09: Misc bit 2 set on motion wakeup; bits 7 to 3 read zero.
// R10: Misc bit 1 set while sample FIFO has data ready.
// R11: Misc bit 0 is command-complete flag polled by host in handshake.
// R12: 8-bit timestamp counts sample sets of fastest enabled sensor.
// R13: Timestamp wraps from 0xff back to 0x00.
// R14: Level mode: status read freezes outputs, drops ready irq, until last read.
// R15: Edge mode: outputs refresh each tick and ready irq pulses once per tick.
// R16: Reading output data status clears its new-data and overrun flags.
module imss_status_top
    import imss_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int SAMPLE_W = 16,
    parameter int RATE_W = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic accel_sample_strb,
    input wire logic gyro_sample_strb,
    input wire logic mag_sample_strb,
    input wire logic orient_result_strb,
    input wire logic [RATE_W-1:0] accel_rate,
    input wire logic [RATE_W-1:0] gyro_rate,
    input wire logic [RATE_W-1:0] mag_rate,
    input wire logic [SAMPLE_W-1:0] accel_x,
    input wire logic [SAMPLE_W-1:0] mag_x,
    input wire logic motion_wakeup_evt,
    input wire logic fifo_ready,
    input wire logic command_done,
    output logic data_ready_irq,
    output logic irq
);
    imss_flag_if fl();

    logic [ADDR_W-3:0] wr_idx_ff;
    logic wr_pend_ff;
    logic [31:0] hrdata_ff;
    logic [7:0] ctrl_ff;
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_mask_ff;
    logic irq_ff;
    logic [7:0] tstamp_ff;
    logic wakeup_ff;
    logic fifo_ready_ff;
    logic cmd_done_ff;
    logic [SAMPLE_W-1:0] mag_hold_ff;
    logic [2*SAMPLE_W-1:0] snap_ff;
    imss_rd_state_t rd_state_ff;
    imss_rd_state_t nxt_rd_state;
    logic dri_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Word index compare against a register index
    function automatic logic idx_is(input logic [ADDR_W-3:0] idx, input logic [7:0] reg_idx);
        return idx == (ADDR_W-2)'(reg_idx);
    endfunction

    // Source of the timestamp: enabled sensor with the highest rate code
    function automatic logic [1:0] fastest(input logic [2:0] en, input logic [RATE_W-1:0] ra,
                                           input logic [RATE_W-1:0] rg,
                                           input logic [RATE_W-1:0] rm);
        logic [1:0] src;
        logic [RATE_W-1:0] best;
        src = 2'h0;
        best = ra;
        if (!en[0] || (en[1] && rg > best)) begin
            src = 2'h1;
            best = rg;
        end
        if (!en[src] || (en[2] && rm > best)) begin
            src = 2'h2;
        end
        return src;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode; zero wait states, so only word accesses are acted upon
    wire [ADDR_W-3:0] addr_idx = haddr[ADDR_W-1:2];
    wire acc_go = hsel & htrans[1] & hready & (hsize == IMSS_HSIZE_WORD);
    wire rd_go = acc_go & ~hwrite;
    wire wr_go = acc_go & hwrite;
    wire st0_rd = rd_go & idx_is(addr_idx, IMSS_IDX_DATA_STATUS);
    wire misc_rd = rd_go & idx_is(addr_idx, IMSS_IDX_MISC);
    wire snap_rd = rd_go & idx_is(addr_idx, IMSS_IDX_SNAPSHOT);
    wire ctrl_wr = wr_pend_ff & idx_is(wr_idx_ff, IMSS_IDX_CTRL);
    wire stat_wr = wr_pend_ff & idx_is(wr_idx_ff, IMSS_IDX_IRQ_STAT);
    wire mask_wr = wr_pend_ff & idx_is(wr_idx_ff, IMSS_IDX_IRQ_MASK);

    wire level_mode = ctrl_ff[IMSS_CTRL_LEVEL_SEL];
    wire accel_g = accel_sample_strb & ctrl_ff[IMSS_CTRL_ACCEL_EN];
    wire gyro_g = gyro_sample_strb & ctrl_ff[IMSS_CTRL_GYRO_EN];
    wire mag_g = mag_sample_strb & ctrl_ff[IMSS_CTRL_MAG_EN];
    wire orient_g = orient_result_strb & ctrl_ff[IMSS_CTRL_ORIENT_EN];
    wire [2:0] sens_en = ctrl_ff[IMSS_CTRL_MAG_EN:IMSS_CTRL_ACCEL_EN];
    wire [1:0] ts_src = fastest(sens_en, accel_rate, gyro_rate, mag_rate);
    wire [2:0] sens_evt = {mag_g, gyro_g, accel_g};
    wire tick = (|sens_en) & sens_evt[ts_src]; // R12

    assign fl.accel_evt = accel_g;
    assign fl.gyro_evt = gyro_g;
    assign fl.mag_evt = mag_g;
    assign fl.orient_evt = orient_g;
    assign fl.mag_en = ctrl_ff[IMSS_CTRL_MAG_EN];
    assign fl.rd_clear = st0_rd; // R16

    imss_sample_flags u_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .fl(fl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Readout: in level mode a load racing a status read is dropped so the frozen copy
    // matches what the host was told
    wire snap_load = tick & (~level_mode | (rd_state_ff == IMSS_RD_LIVE & ~st0_rd)); // R14 R15
    // Mag result missing this tick: repeat the held one
    wire [SAMPLE_W-1:0] mag_pick = mag_g ? mag_x : mag_hold_ff; // R08
    wire nxt_dri = level_mode ? (snap_load | (dri_ff & ~st0_rd)) : tick; // R14 R15

    always_comb begin
        nxt_rd_state = rd_state_ff;
        unique case (rd_state_ff)
            IMSS_RD_LIVE: begin
                if (level_mode && st0_rd) begin
                    nxt_rd_state = IMSS_RD_FROZEN; // R14
                end
            end
            IMSS_RD_FROZEN: begin
                if (!level_mode || snap_rd) begin
                    nxt_rd_state = IMSS_RD_LIVE; // R14
                end
            end
        endcase
    end

    wire [7:0] misc_word = {5'h00, wakeup_ff, fifo_ready_ff, cmd_done_ff}; // R09 R10 R11
    wire nxt_wakeup = (wakeup_ff & ~misc_rd) | motion_wakeup_evt; // R09
    wire [3:0] irq_evt = {command_done & ~cmd_done_ff, motion_wakeup_evt, fl.ovrn_evt, snap_load};
    wire [3:0] nxt_irq_stat = (irq_stat_ff & ~({4{stat_wr}} & hwdata[3:0])) | irq_evt;
    wire [3:0] nxt_irq_mask = mask_wr ? hwdata[3:0] : irq_mask_ff;
    wire [31:0] rd_word =
        idx_is(addr_idx, IMSS_IDX_DATA_STATUS) ? {24'h000000, fl.data_status} :
        idx_is(addr_idx, IMSS_IDX_MISC) ? {24'h000000, misc_word} :
        idx_is(addr_idx, IMSS_IDX_TSTAMP) ? {24'h000000, tstamp_ff} :
        idx_is(addr_idx, IMSS_IDX_CTRL) ? {24'h000000, ctrl_ff} :
        idx_is(addr_idx, IMSS_IDX_IRQ_STAT) ? {28'h0000000, irq_stat_ff} :
        idx_is(addr_idx, IMSS_IDX_IRQ_MASK) ? {28'h0000000, irq_mask_ff} :
        idx_is(addr_idx, IMSS_IDX_SNAPSHOT) ? 32'(snap_ff) : IMSS_RST_WORD;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= '0;
            hrdata_ff <= IMSS_RST_WORD;
        end else begin
            wr_pend_ff <= wr_go;
            wr_idx_ff <= wr_go ? addr_idx : wr_idx_ff;
            hrdata_ff <= rd_go ? rd_word : hrdata_ff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= IMSS_RST_BYTE;
            irq_stat_ff <= IMSS_RST_IRQ;
            irq_mask_ff <= IMSS_RST_IRQ;
            irq_ff <= 1'b0;
        end else begin
            ctrl_ff <= ctrl_wr ? hwdata[7:0] : ctrl_ff;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tstamp_ff <= IMSS_RST_BYTE;
            wakeup_ff <= 1'b0;
            fifo_ready_ff <= 1'b0;
            cmd_done_ff <= 1'b0;
        end else begin
            tstamp_ff <= tick ? 8'(tstamp_ff + 8'h01) : tstamp_ff; // R12 R13
            wakeup_ff <= nxt_wakeup; // R09
            fifo_ready_ff <= fifo_ready; // R10
            cmd_done_ff <= command_done; // R11
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mag_hold_ff <= '0;
            snap_ff <= '0;
            rd_state_ff <= IMSS_RD_LIVE;
            dri_ff <= 1'b0;
        end else begin
            mag_hold_ff <= mag_pick; // R08
            snap_ff <= snap_load ? {mag_pick, accel_x} : snap_ff; // R15
            rd_state_ff <= nxt_rd_state;
            dri_ff <= nxt_dri;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign data_ready_irq = dri_ff;
    assign irq = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_level_status_read;
        level_mode && st0_rd;
    endsequence

    chk_ts_step: assert property (tick |=> tstamp_ff == 8'($past(tstamp_ff) + 8'h01)) // R12
        else $error("timestamp did not step on tick");
    chk_ts_wrap: assert property ((tick && tstamp_ff == 8'hff) |=> tstamp_ff == 8'h00) // R13
        else $error("timestamp did not wrap");
    chk_freeze_hold: assert property (
        s_level_status_read ##1 (!snap_rd && level_mode) |=> $stable(snap_ff)) // R14
        else $error("snapshot changed while frozen");
    chk_ready_drop: assert property (s_level_status_read |=> !data_ready_irq) // R14
        else $error("ready irq not dropped by status read");
    chk_edge_pulse: assert property (
        (!level_mode && tick) |=> data_ready_irq && snap_ff[SAMPLE_W-1:0] == $past(accel_x)) // R15
        else $error("edge mode refresh or pulse missing");
    chk_mag_repeat: assert property (
        (snap_load && !mag_g) |=> snap_ff[2*SAMPLE_W-1:SAMPLE_W] == $past(mag_hold_ff)) // R08
        else $error("held magnetometer result not repeated");
    chk_wakeup_flag: assert property ( // R09
        motion_wakeup_evt |=> misc_word[2] && misc_word[7:3] == 5'h00)
        else $error("wakeup flag not set");
    chk_fifo_cmd_bits: assert property (
        1'b1 |=> misc_word[1:0] == {$past(fifo_ready), $past(command_done)}) // R10 R11
        else $error("fifo or command flag wrong");
    chk_irq_level: assert property (irq == |(irq_stat_ff & irq_mask_ff))
        else $error("interrupt output mismatch");

    // Bus side: read data, register writes and interrupt bookkeeping
    chk_rd_load: assert property (rd_go |=> hrdata == $past(rd_word))
        else $error("read data not loaded");
    chk_rd_hold: assert property (!rd_go |=> $stable(hrdata))
        else $error("read data changed without a read");
    chk_ctrl_write: assert property (ctrl_wr |=> ctrl_ff == $past(hwdata[7:0]))
        else $error("control write lost");
    chk_mask_write: assert property (mask_wr |=> irq_mask_ff == $past(hwdata[3:0]))
        else $error("mask write lost");
    chk_irq_w1c: assert property (
        (stat_wr && irq_evt == 4'h0) |=> (irq_stat_ff & $past(hwdata[3:0])) == 4'h0)
        else $error("interrupt status not cleared by write");
    chk_irq_set_wins: assert property (
        irq_evt != 4'h0 |=> (irq_stat_ff & $past(irq_evt)) == $past(irq_evt))
        else $error("interrupt event lost");
    chk_ovrn_irq: assert property (fl.ovrn_evt |=> irq_stat_ff[IMSS_IRQ_OVRN])
        else $error("overrun interrupt not raised");
    chk_cmd_edge: assert property ( // R11
        (command_done && !cmd_done_ff) |=> irq_stat_ff[IMSS_IRQ_CMD])
        else $error("command completion interrupt not raised");

    // Readout side: timestamp, freeze, ready pulse and wakeup flag clear
    sequence s_frozen_snap_read;
        rd_state_ff == IMSS_RD_FROZEN && snap_rd;
    endsequence
    sequence s_level_load;
        level_mode && snap_load;
    endsequence

    chk_ts_hold: assert property (!tick |=> $stable(tstamp_ff)) // R12
        else $error("timestamp moved without a tick");
    chk_unfreeze: assert property (s_frozen_snap_read |=> rd_state_ff == IMSS_RD_LIVE) // R14
        else $error("snapshot read did not release freeze");
    chk_frozen_no_load: assert property ( // R14
        (level_mode && rd_state_ff == IMSS_RD_FROZEN) |-> !snap_load)
        else $error("snapshot loaded while frozen");
    chk_level_raise: assert property (s_level_load |=> data_ready_irq) // R14
        else $error("ready irq not raised on load");
    chk_snap_hold: assert property (!snap_load |=> $stable(snap_ff)) // R14 R15
        else $error("snapshot changed without a load");
    chk_edge_idle: assert property ((!level_mode && !tick) |=> !data_ready_irq) // R15
        else $error("ready irq high without a tick");
    chk_wakeup_clear: assert property ((misc_rd && !motion_wakeup_evt) |=> !misc_word[2]) // R09
        else $error("wakeup flag not cleared by read");
endmodule

// ---- testbench/imss_sensor_model.sv ----
`timescale 1ns/1ns
// Sensor front end: one strobe a cycle after each fire request, data valid only while strobed
module imss_sensor_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] fire,
    output logic [3:0] strb,
    output logic [15:0] accel_x,
    output logic [15:0] mag_x
);
    logic [15:0] acc_ff;
    logic [15:0] mag_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strb <= 4'h0;
            acc_ff <= 16'h0000;
            mag_ff <= 16'h1000;
        end else begin
            strb <= fire;
            acc_ff <= acc_ff + {15'h0000, fire[0]};
            mag_ff <= mag_ff + {15'h0000, fire[2]};
        end
    end

    // Off-strobe the lines flip, so a capture at the wrong moment shows as bad data
    assign accel_x = strb[0] ? acc_ff : ~acc_ff;
    assign mag_x = strb[2] ? mag_ff : ~mag_ff;
endmodule

// ---- testbench/imu_status_sample_counter_test.sv ----
`timescale 1ns/1ns
module imu_status_sample_counter_test
    import imss_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, data_ready_irq, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, accel_rate, gyro_rate, mag_rate;
    logic [3:0] fire_req, strb;
    logic [15:0] accel_x, mag_x, acc_n, mag_n;
    logic motion_wakeup_evt, fifo_ready, command_done, ts_on;
    logic [7:0] ts_exp;
    logic [31:0] se;
    int fail_count, tests_run, dri_cnt, dri_seen;

    imss_status_top imss_status_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .accel_sample_strb(strb[0]), .gyro_sample_strb(strb[1]),
        .mag_sample_strb(strb[2]), .orient_result_strb(strb[3]),
        .accel_rate(accel_rate), .gyro_rate(gyro_rate), .mag_rate(mag_rate),
        .accel_x(accel_x), .mag_x(mag_x), .motion_wakeup_evt(motion_wakeup_evt),
        .fifo_ready(fifo_ready), .command_done(command_done),
        .data_ready_irq(data_ready_irq), .irq(irq)
    );

    imss_sensor_model imss_sensor_model_inst (
        .hclk(hclk), .hresetn(hresetn), .fire(fire_req), .strb(strb),
        .accel_x(accel_x), .mag_x(mag_x)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One single word transfer; the watchdog bounds the waits on hready
    task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h000000, idx, 2'b00};
        hwrite <= w;
        hsize <= IMSS_HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        bus(idx, 1'b0, 32'h0000_0000, v);
        check(v, exp);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] v;
        bus(idx, 1'b1, d, v);
    endtask

    task automatic pin(input logic v, input logic e);
        check({31'h0, v}, {31'h0, e});
    endtask

    task automatic fire(input logic [3:0] m);
        fire_req <= m;
        @(posedge hclk);
        fire_req <= 4'h0;
        repeat (2) @(posedge hclk);
        acc_n = acc_n + {15'h0000, m[0]};
        mag_n = mag_n + {15'h0000, m[2]};
        if (m[0] && ts_on) ts_exp++;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // Whole run is under a thousand cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        stop_test();
    end

    always @(posedge hclk) begin
        if (data_ready_irq === 1'b1) begin
            dri_cnt <= dri_cnt + 1;
        end
    end

    initial begin
        logic [7:0] regs [8] = '{8'h16, 8'h17, 8'h18, 8'h20, 8'h21, 8'h22, 8'h23, 8'h10};
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = IMSS_HSIZE_WORD;
        hwdata = 32'h0000_0000;
        accel_rate = 3'h4;
        gyro_rate = 3'h2;
        mag_rate = 3'h1;
        fire_req = 4'h0;
        motion_wakeup_evt = 1'b0;
        fifo_ready = 1'b0;
        command_done = 1'b0;
        acc_n = 16'h0000;
        mag_n = 16'h0000;
        ts_exp = 8'h00;
        ts_on = 1'b0;
        fail_count = 0;
        tests_run = 0;
        dri_cnt = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (regs[i]) rd(regs[i], 32'h0000_0000);
        wr(IMSS_IDX_TSTAMP, 32'h0000_0055);
        rd(IMSS_IDX_TSTAMP, 32'h0000_0000);
        wr(8'h10, 32'h0000_00ff);
        rd(8'h10, 32'h0000_0000);
        pin(hresp, 1'b0);
        pin(hreadyout, 1'b1);
        fire(4'h1);
        rd(IMSS_IDX_DATA_STATUS, 32'h0000_0000);
        $display("test reset_and_access done");

        wr(IMSS_IDX_CTRL, 32'h0000_000f);
        ts_on = 1'b1;
        fire(4'hb);
        rd(IMSS_IDX_DATA_STATUS, 32'h0000_000b);
        fire(4'hb);
        fire(4'hb);
        rd(IMSS_IDX_DATA_STATUS, 32'h0000_00bb);
        rd(IMSS_IDX_DATA_STATUS, 32'h0000_0000);
        fire(4'h4);
        rd(IMSS_IDX_DATA_STATUS, 32'h0000_0004);
        fire(4'h4);
        fire(4'h4);
        rd(IMSS_IDX_DATA_STATUS, 32'h0000_0044);
        rd(IMSS_IDX_DATA_STATUS, 32'h0000_0004);
        rd(IMSS_IDX_TSTAMP, {24'h0, ts_exp});
        $display("test status_flags done");

        dri_seen = dri_cnt;
        repeat (3) fire(4'h1);
        // The last pulse is counted by a non-blocking update at this very edge
        @(posedge hclk);
        check(dri_cnt - dri_seen, 3);
        rd(IMSS_IDX_SNAPSHOT, {16'h1000 + mag_n, acc_n});
        repeat (249) fire(4'h1);
        rd(IMSS_IDX_TSTAMP, 32'h0000_00ff);
        fire(4'h1);
        rd(IMSS_IDX_TSTAMP, 32'h0000_0000);
        rd(IMSS_IDX_DATA_STATUS, 32'h0000_0015);
        $display("test edge_mode_and_wrap done");

        rd(IMSS_IDX_IRQ_STAT, 32'h0000_0003);
        pin(irq, 1'b0);
        wr(IMSS_IDX_IRQ_MASK, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        pin(irq, 1'b1);
        wr(IMSS_IDX_IRQ_STAT, 32'h0000_0003);
        repeat (3) @(posedge hclk);
        pin(irq, 1'b0);
        rd(IMSS_IDX_IRQ_STAT, 32'h0000_0000);
        fire(4'h1);
        repeat (1) @(posedge hclk);
        pin(irq, 1'b1);
        wr(IMSS_IDX_IRQ_STAT, 32'h0000_0001);
        motion_wakeup_evt <= 1'b1;
        @(posedge hclk);
        motion_wakeup_evt <= 1'b0;
        repeat (2) @(posedge hclk);
        pin(irq, 1'b0);
        rd(IMSS_IDX_MISC, 32'h0000_0004);
        rd(IMSS_IDX_MISC, 32'h0000_0000);
        fifo_ready <= 1'b1;
        command_done <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(IMSS_IDX_MISC, 32'h0000_0003);
        rd(IMSS_IDX_IRQ_STAT, 32'h0000_000c);
        wr(IMSS_IDX_IRQ_STAT, 32'h0000_000f);
        rd(IMSS_IDX_IRQ_STAT, 32'h0000_0000);
        fifo_ready <= 1'b0;
        command_done <= 1'b0;
        repeat (2) @(posedge hclk);
        rd(IMSS_IDX_MISC, 32'h0000_0000);
        $display("test interrupts_and_misc done");

        wr(IMSS_IDX_CTRL, 32'h0000_008f);
        fire(4'h1);
        se = {16'h1000 + mag_n, acc_n};
        repeat (3) @(posedge hclk);
        pin(data_ready_irq, 1'b1);
        rd(IMSS_IDX_DATA_STATUS, 32'h0000_0015);
        repeat (1) @(posedge hclk);
        pin(data_ready_irq, 1'b0);
        fire(4'h1);
        repeat (1) @(posedge hclk);
        pin(data_ready_irq, 1'b0);
        rd(IMSS_IDX_SNAPSHOT, se);
        fire(4'h1);
        repeat (1) @(posedge hclk);
        pin(data_ready_irq, 1'b1);
        rd(IMSS_IDX_SNAPSHOT, {16'h1000 + mag_n, acc_n});
        $display("test level_mode done");

        // Gyro becomes the fastest source: accel strobes stop counting
        gyro_rate <= 3'h7;
        ts_on = 1'b0;
        fire(4'h1);
        rd(IMSS_IDX_TSTAMP, {24'h0, ts_exp});
        fire(4'h2);
        rd(IMSS_IDX_TSTAMP, {24'h0, ts_exp + 8'h01});
        $display("test rate_select done");
        stop_test();
    end
endmodule
